// ===== rtl/isp_params.svh
// constants for the in-system flash programming slave
`ifndef ISP_PARAMS_SVH
`define ISP_PARAMS_SVH

// software enable key
`define KEY_ENABLE      8'h93

// command field codes (upper five bits of the command byte)
`define CMD_PROGRAM     5'h14
`define CMD_PAGE_ERASE  5'h06
`define CMD_BLANK       5'h0D
`define CMD_CLR_CRC     5'h1A
`define CMD_RESET_CPU   5'h09

// byte field positions
`define CMD_FIELD       7:3
`define FONT_SEL        0
`define TXN_FIELD       1:0
`define PEER_FIELD      7:2
`define FONT_LO         6:0
`define HI_BYTE         15:8
`define LO_BYTE         7:0

// byte index within a transfer (0 is the address byte)
`define IDX_ADDR        3'h0
`define IDX_SECOND      3'h1
`define IDX_THIRD       3'h2
`define IDX_FOURTH      3'h3
`define IDX_FIFTH       3'h4
`define IDX_SIXTH       3'h5
`define IDX_MAX         3'h7

// values
`define CRC_SEED        16'hFFFF
`define FILL_BYTE       8'hFF
`define BIT_COUNT       4'h8
`define LAST_BIT        4'h7

// timing
`define CLK_PERIOD_NS   4
`define HANDOVER_NS     15000
`define ERASE_NS        10000000
`define PROGRAM_NS      60000

`endif

// ===== rtl/isp_pkg.sv
// types shared by the flash programming slave and its bus bit engine
package isp_pkg;

	typedef enum logic [1:0] {
		TXN_DATA_WR = 2'h0,
		TXN_DATA_RD = 2'h1,
		TXN_CMD_WR  = 2'h2,
		TXN_CMD_RD  = 2'h3
	} txn_t;

	typedef enum logic [2:0] {
		FL_READ       = 3'h0,
		FL_PROGRAM    = 3'h1,
		FL_PAGE_ERASE = 3'h2,
		FL_BLANK      = 3'h3
	} flash_op_t;

	typedef enum logic [4:0] {
		PH_IDLE   = 5'h01,
		PH_RX     = 5'h02,
		PH_RX_ACK = 5'h04,
		PH_TX     = 5'h08,
		PH_TX_ACK = 5'h10
	} bus_phase_t;

	typedef struct packed {
		bus_phase_t  phase;
		logic [3:0]  cnt;
		logic [7:0]  shreg;
		logic        oe;
		logic        acked;
	} bus_state_t;

	typedef struct packed {
		logic        start;
		logic        stop;
		logic        byte_valid;
		logic        host_ack;
		logic [7:0]  data;
	} bus_ev_t;

	typedef struct packed {
		logic        strobe;
		flash_op_t   op;
		logic        font;
		logic [15:0] addr;
		logic [15:0] wdata;
	} flash_cmd_t;

	typedef struct packed {
		txn_t        txn;
		logic [2:0]  idx;
		logic        matched;
		logic        ack;
		logic        tx_mode;
		logic [7:0]  tx_byte;
		logic [7:0]  cmd;
		logic [7:0]  addr_hi;
		logic [7:0]  addr_lo;
		logic [7:0]  font_hi;
		logic        half;
		logic [15:0] crc;
	} xfer_t;

	typedef struct packed {
		logic        armed;
		logic        active;
		logic [11:0] cnt;
	} mode_t;

endpackage

// ===== rtl/isp_bit_engine.sv
// two-wire bus bit engine: synchronises the pins, frames bytes, drives ack and read data
`timescale 1ns/100ps
`default_nettype none

`include "isp_params.svh"

module isp_bit_engine (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rst_n_i,
	// bus pins
	input  wire logic             scl_i,
	input  wire logic             sda_i,
	output logic                  sda_o,
	output logic                  sda_oe_o,
	// byte level side
	input  wire logic             ack_i,
	input  wire logic             tx_mode_i,
	input  wire logic [7:0]       tx_byte_i,
	output isp_pkg::bus_ev_t      ev_o
);
	import isp_pkg::*;

	logic [2:0]  scl_s;
	logic [2:0]  sda_s;
	bus_state_t  st;
	bus_state_t  next_st;
	bus_ev_t     next_ev;
	logic        scl_rise;
	logic        scl_fall;

	// stage 0 feeds only stage 1; stage 2 is the previous value for edge finding
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
		end else begin
			scl_s <= {scl_s[1:0], scl_i};
			sda_s <= {sda_s[1:0], sda_i};
		end
	end

	assign scl_rise = scl_s[1] & ~scl_s[2];
	assign scl_fall = ~scl_s[1] & scl_s[2];
	assign sda_o    = 1'b0;
	assign sda_oe_o = st.oe;

	always_comb begin
		next_st = st;
		next_ev = '0;
		next_ev.data = st.shreg;
		if (scl_s[1] && scl_s[2] && !sda_s[1] && sda_s[2]) begin
			next_st.phase = PH_RX;
			next_st.cnt   = 4'h0;
			next_st.oe    = 1'b0;
			next_ev.start = 1'b1;
		end else if (scl_s[1] && scl_s[2] && sda_s[1] && !sda_s[2]) begin
			next_st.phase = PH_IDLE;
			next_st.oe    = 1'b0;
			next_ev.stop  = 1'b1;
		end else begin
			case (st.phase)
				PH_RX: begin
					if (scl_rise) begin
						next_st.shreg = {st.shreg[6:0], sda_s[1]};
						next_st.cnt   = st.cnt + 4'h1;
						if (st.cnt == `LAST_BIT) begin
							next_ev.byte_valid = 1'b1;
							next_ev.data       = {st.shreg[6:0], sda_s[1]};
						end
					end else if (scl_fall && st.cnt == `BIT_COUNT) begin
						// a refused byte leaves the bus alone until the next start
						next_st.oe    = ack_i;
						next_st.phase = ack_i ? PH_RX_ACK : PH_IDLE;
					end
				end
				PH_RX_ACK: begin
					if (scl_fall) begin
						next_st.cnt = 4'h0;
						if (tx_mode_i) begin
							next_st.shreg = tx_byte_i;
							next_st.oe    = ~tx_byte_i[7];
							next_st.phase = PH_TX;
						end else begin
							next_st.oe    = 1'b0;
							next_st.phase = PH_RX;
						end
					end
				end
				PH_TX: begin
					if (scl_rise) begin
						next_st.cnt = st.cnt + 4'h1;
					end else if (scl_fall) begin
						if (st.cnt == `BIT_COUNT) begin
							next_st.oe    = 1'b0;
							next_st.phase = PH_TX_ACK;
						end else begin
							next_st.shreg = {st.shreg[6:0], 1'b0};
							next_st.oe    = ~st.shreg[6];
						end
					end
				end
				PH_TX_ACK: begin
					if (scl_rise) begin
						next_st.acked    = ~sda_s[1];
						next_ev.host_ack = 1'b1;
					end else if (scl_fall) begin
						next_st.cnt = 4'h0;
						if (st.acked) begin
							next_st.shreg = tx_byte_i;
							next_st.oe    = ~tx_byte_i[7];
							next_st.phase = PH_TX;
						end else begin
							next_st.phase = PH_IDLE;
						end
					end
				end
				default: begin
					next_st.oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st       <= '{phase: PH_IDLE, cnt: 4'h0, shreg: 8'h00, oe: 1'b0, acked: 1'b0};
			ev_o     <= '0;
		end else begin
			st       <= next_st;
			ev_o     <= next_ev;
		end
	end

endmodule

`default_nettype wire

// ===== rtl/i2c_flash_program_slave.sv
// in-system flash programming slave: transfer decode, flash sequencing, address and crc
//
// Operation
// R01: programming mode arms on key 93h write, activates only once cpu is idle.
// R02: after enable, suppress watchdog and hand flash to host within 15-22.5 us.
// R03: address byte low bits pick command write, command read, data write, data read.
// R04: command field codes select program, page erase or blank for data writes.
// R05: command 11010 reseeds the crc; command 01001 resets the processor.
// R06: command bit 0 selects font array, else code array; bits 2:1 ignored.
// R07: third command-write byte loads page address; writes may stop after any byte.
// R08: command read returns command, address high, address low, crc high, crc low.
// R09: second data-write byte loads the low address.
// R10: from third data-write byte, run the last commanded program, erase or blank.
// R11: low address steps per code byte, or per second byte for font words.
// R12: erase/blank take one ignored byte; nack all traffic for 10 ms after.
// R13: host sends 1-256 code bytes or 1-128 font words per program transfer.
// R14: byte arriving during 60 us program cycle is nacked, uncounted, address held.
// R15: host waits 10 ms after erase/blank and 60 us between program bytes.
// R16: page erase clears 256 code bytes or 128 font words; blank clears array.
// R17: host acks read bytes as it likes; address setup ends with stop or restart.
// R18: host keeps the bus clock at or below 140 kHz.
// R19: crc seeded to all ones by reset or clear; counts acked data bytes only.
// R20: crc shifts msb first with feedback into bits 15, 2 and 0.
// R21: readback sends flash from loaded address, stepping after each byte or word.
// R22: font word travels upper byte first, lower eight bits second.
// R23: answer only the peer address held in the programming address register.
`timescale 1ns/100ps
`default_nettype none

`include "isp_params.svh"

module i2c_flash_program_slave #(
	parameter int unsigned ERASE_CYCLES   = (`ERASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int unsigned PROGRAM_CYCLES = (`PROGRAM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_n_i,
	// software control
	input  wire logic                 key_wr_i,
	input  wire logic [7:0]           program_mode_key_reg_i,
	input  wire logic [7:0]           program_peer_address_reg_i,
	input  wire logic                 cpu_idle_i,
	// system status
	output logic                      program_mode_o,
	output logic                      wdt_suppress_o,
	output logic                      cpu_reset_o,
	output logic                      busy_o,
	// bus pins
	input  wire logic                 scl_i,
	input  wire logic                 sda_i,
	output logic                      sda_o,
	output logic                      sda_oe_o,
	// flash arrays
	output isp_pkg::flash_cmd_t       flash_cmd_o,
	input  wire logic [15:0]          flash_rdata_i
);
	import isp_pkg::*;

	localparam int unsigned HANDOVER_CYCLES = (`HANDOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
	localparam int unsigned TMR_W           = $clog2(ERASE_CYCLES + 1);

	bus_ev_t              ev;
	mode_t                m;
	mode_t                next_m;
	xfer_t                x;
	xfer_t                next_x;
	flash_cmd_t           next_fl;
	logic [TMR_W-1:0]     tmr;
	logic [TMR_W-1:0]     next_tmr;
	logic                 long_op;
	logic                 next_long_op;
	logic                 next_cpu_reset;
	logic                 long_busy;
	logic                 font;
	logic [4:0]           field;

	function automatic logic [15:0] flash_addr(input logic f, input logic [7:0] hi,
		input logic [7:0] lo);
		flash_addr = f ? {2'h0, hi[`FONT_LO], lo[`FONT_LO]} : {hi, lo};
	endfunction

	function automatic logic [7:0] step_lo(input logic f, input logic [7:0] lo);
		step_lo = f ? {1'b0, lo[`FONT_LO] + 7'h01} : lo + 8'h01; // see R13
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		logic        fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = r[15] ^ d[i];
			r  = {r[14] ^ fb, r[13:2], r[1] ^ fb, r[0], fb}; // see R20
		end
		crc_step = r;
	endfunction

	isp_bit_engine u_bits (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.sda_o      (sda_o),
		.sda_oe_o   (sda_oe_o),
		.ack_i      (x.ack),
		.tx_mode_i  (x.tx_mode),
		.tx_byte_i  (x.tx_byte),
		.ev_o       (ev)
	);

	assign program_mode_o = m.active;
	assign wdt_suppress_o = m.active;
	assign busy_o         = (tmr != '0);
	assign long_busy      = long_op && (tmr != '0);
	assign font           = x.cmd[`FONT_SEL]; // see R06
	assign field          = ev.data[`CMD_FIELD];

	// mode entry: key arms, idle cpu starts the handover count
	always_comb begin
		next_m = m;
		if (key_wr_i && !m.active) begin
			next_m.armed = (program_mode_key_reg_i == `KEY_ENABLE); // see R01
		end
		if (m.armed && cpu_idle_i && !m.active) begin
			if (m.cnt == 12'(HANDOVER_CYCLES - 1)) begin
				next_m.active = 1'b1; // see R02
			end else begin
				next_m.cnt = m.cnt + 12'h001;
			end
		end else if (!m.active) begin
			next_m.cnt = 12'h000; // see R01
		end
		if (cpu_reset_o) begin
			next_m = '0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			m <= '0;
		end else begin
			m <= next_m;
		end
	end

	// transfer decode, flash sequencing and crc
	always_comb begin
		next_x         = x;
		next_fl        = flash_cmd_o;
		next_fl.strobe = 1'b0;
		next_fl.op     = FL_READ;
		next_fl.font   = font;
		next_fl.addr   = flash_addr(font, x.addr_hi, x.addr_lo); // see R21
		next_tmr       = (tmr != '0) ? tmr - 1'b1 : tmr;
		next_long_op   = long_op;
		next_cpu_reset = 1'b0;

		if (ev.start) begin
			next_x.idx     = `IDX_ADDR;
			next_x.matched = 1'b0;
			next_x.tx_mode = 1'b0;
		end
		if (ev.stop) begin
			next_x.matched = 1'b0;
			next_x.tx_mode = 1'b0;
		end

		if (ev.byte_valid && x.idx == `IDX_ADDR) begin
			// busy with erase or blank: even our own address goes unanswered
			next_x.matched = m.active && !long_busy &&
				(ev.data[`PEER_FIELD] == program_peer_address_reg_i[`PEER_FIELD]); // see R23, R12
			next_x.ack     = next_x.matched;
			next_x.txn     = txn_t'(ev.data[`TXN_FIELD]); // see R03
			next_x.tx_mode = next_x.matched && ev.data[0];
			next_x.idx     = `IDX_SECOND;
			if (next_x.matched && next_x.txn == TXN_DATA_RD) begin
				next_x.half = 1'b0;
			end
		end else if (ev.byte_valid) begin
			next_x.idx = (x.idx == `IDX_MAX) ? x.idx : x.idx + 3'h1;
			next_x.ack = x.matched && !long_busy; // see R12
			if (x.matched && !long_busy) begin
				case (x.txn)
					TXN_CMD_WR: begin
						if (x.idx == `IDX_SECOND) begin
							next_x.cmd = ev.data; // see R04
							if (field == `CMD_CLR_CRC) begin
								next_x.crc = `CRC_SEED; // see R05, R19
							end
							if (field == `CMD_RESET_CPU) begin
								next_cpu_reset = 1'b1; // see R05
							end
						end else if (x.idx == `IDX_THIRD) begin
							next_x.addr_hi = font ? {1'b0, ev.data[`FONT_LO]} : ev.data; // see R07
						end
					end
					TXN_DATA_WR: begin
						if (x.idx == `IDX_SECOND) begin
							next_x.addr_lo = font ? {1'b0, ev.data[`FONT_LO]} : ev.data; // see R09
							next_x.half    = 1'b0;
						end else begin
							case (x.cmd[`CMD_FIELD]) // see R10
								`CMD_PROGRAM: begin
									if (tmr != '0) begin
										next_x.ack = 1'b0; // see R14
									end else begin
										next_x.crc = crc_step(x.crc, ev.data); // see R19
										if (font && !x.half) begin
											next_x.font_hi = ev.data; // see R22
											next_x.half    = 1'b1;
										end else begin
											next_fl.strobe = 1'b1;
											next_fl.op     = FL_PROGRAM;
											next_fl.wdata  = font ? {x.font_hi, ev.data}
												: {8'h00, ev.data};
											next_tmr       = TMR_W'(PROGRAM_CYCLES); // see R14
											next_long_op   = 1'b0;
											next_x.addr_lo = step_lo(font, x.addr_lo); // see R11
											next_x.half    = 1'b0;
										end
									end
								end
								`CMD_PAGE_ERASE,
								`CMD_BLANK: begin
									if (x.idx == `IDX_THIRD) begin
										next_fl.strobe = 1'b1;
										next_fl.op     = (x.cmd[`CMD_FIELD] == `CMD_BLANK)
											? FL_BLANK : FL_PAGE_ERASE; // see R16
										next_tmr       = TMR_W'(ERASE_CYCLES); // see R12
										next_long_op   = 1'b1;
									end else begin
										next_x.ack = 1'b0;
									end
								end
								default: begin
									next_x.crc = crc_step(x.crc, ev.data); // see R19
								end
							endcase
						end
					end
					default: begin
						next_x.ack = 1'b0;
					end
				endcase
			end
		end

		if (ev.host_ack && x.tx_mode) begin // see R17
			next_x.idx = (x.idx == `IDX_MAX) ? x.idx : x.idx + 3'h1;
			if (x.txn == TXN_DATA_RD) begin
				if (!font || x.half) begin
					next_x.addr_lo = step_lo(font, x.addr_lo); // see R21
					next_x.half    = 1'b0;
				end else begin
					next_x.half = 1'b1;
				end
			end
		end

		// read data is refreshed every cycle; the engine takes it at the scl fall
		next_x.tx_byte = `FILL_BYTE;
		if (x.txn == TXN_CMD_RD) begin
			case (x.idx) // see R08
				`IDX_SECOND: next_x.tx_byte = x.cmd;
				`IDX_THIRD:  next_x.tx_byte = x.addr_hi;
				`IDX_FOURTH: next_x.tx_byte = x.addr_lo;
				`IDX_FIFTH:  next_x.tx_byte = x.crc[`HI_BYTE];
				`IDX_SIXTH:  next_x.tx_byte = x.crc[`LO_BYTE];
				default:     next_x.tx_byte = `FILL_BYTE;
			endcase
		end else if (x.txn == TXN_DATA_RD) begin
			next_x.tx_byte = (font && !x.half) ? flash_rdata_i[`HI_BYTE]
				: flash_rdata_i[`LO_BYTE]; // see R22
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			x           <= '{txn: TXN_DATA_WR, idx: `IDX_ADDR, tx_byte: `FILL_BYTE,
				crc: `CRC_SEED, default: '0};
			flash_cmd_o <= '{op: FL_READ, default: '0};
			tmr         <= '0;
			long_op     <= 1'b0;
			cpu_reset_o <= 1'b0;
		end else begin
			x           <= next_x;
			flash_cmd_o <= next_fl;
			tmr         <= next_tmr;
			long_op     <= next_long_op;
			cpu_reset_o <= next_cpu_reset;
		end
	end

endmodule

`default_nettype wire

// ===== sim/i2c_flash_program_slave_monitor.sv
// concurrent checks on the ports of the flash programming slave
`timescale 1ns/100ps
`default_nettype none

module i2c_flash_program_slave_monitor #(
	parameter int unsigned	ERASE_CYCLES	= 2500000,
	parameter int unsigned	PROGRAM_CYCLES	= 15000
) (
	// clock and reset
	input wire logic			core_clk_i,
	input wire logic			rst_n_i,
	// watched ports
	input wire logic			cpu_idle_i,
	input wire logic			program_mode_o,
	input wire logic			wdt_suppress_o,
	input wire logic			cpu_reset_o,
	input wire logic			busy_o,
	input wire logic			sda_oe_o,
	input wire isp_pkg::flash_cmd_t	flash_cmd_o
);
	import isp_pkg::*;

	logic [23:0]	busy_len, next_busy_len, idle_len, next_idle_len, erase_age, next_erase_age;
	logic		erase_go;

	// erase age keeps running a few cycles before busy shows, then as long as busy stands
	always_comb begin
		erase_go = flash_cmd_o.strobe && (flash_cmd_o.op inside {FL_PAGE_ERASE, FL_BLANK});
		next_busy_len = busy_o ? busy_len + 24'h1 : 24'h0;
		next_idle_len = cpu_idle_i ? idle_len + 24'h1 : 24'h0;
		next_erase_age = erase_go ? 24'h1 :
			(erase_age != 24'h0 && (busy_o || erase_age < 24'h8)) ? erase_age + 24'h1 : 24'h0;
	end
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_len <= 24'h0;
			idle_len <= 24'h0;
			erase_age <= 24'h0;
		end else begin
			busy_len <= next_busy_len;
			idle_len <= next_idle_len;
			erase_age <= next_erase_age;
		end
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	a_watchdog_follows_mode: assert property (
		wdt_suppress_o == program_mode_o) else $error("watchdog suppress differs from mode");
	a_mode_after_idle: assert property (
		$rose(program_mode_o) |-> idle_len >= 24'hEA6) else $error("mode rose too early");
	a_strobe_needs_mode: assert property (
		flash_cmd_o.strobe |-> program_mode_o) else $error("flash strobe outside program mode");
	a_strobe_sets_busy: assert property (
		flash_cmd_o.strobe && flash_cmd_o.op != FL_READ |-> ##[0:2] busy_o)
		else $error("flash operation without busy");
	a_no_strobe_busy: assert property (
		flash_cmd_o.strobe |-> !$past(busy_o)) else $error("flash strobe while busy");
	a_busy_exact_len: assert property (
		$fell(busy_o) |-> (busy_len == PROGRAM_CYCLES || busy_len == ERASE_CYCLES))
		else $error("busy time wrong");
	a_erase_nack_all: assert property (
		erase_age > 24'h28 |-> !sda_oe_o) else $error("ack during erase");
	a_cpu_reset_ends: assert property (
		cpu_reset_o |=> !program_mode_o && !cpu_reset_o) else $error("mode kept after cpu reset");
	a_font_addr_form: assert property (
		flash_cmd_o.strobe && flash_cmd_o.font |-> flash_cmd_o.addr[15:14] == 2'h0)
		else $error("font address too wide");

	cover property ($rose(program_mode_o));
	cover property (erase_go);
	cover property (cpu_reset_o);
endmodule

bind i2c_flash_program_slave i2c_flash_program_slave_monitor #(
	.ERASE_CYCLES	(ERASE_CYCLES),
	.PROGRAM_CYCLES	(PROGRAM_CYCLES)
) mon_inst (
	.core_clk_i	(core_clk_i),
	.rst_n_i	(rst_n_i),
	.cpu_idle_i	(cpu_idle_i),
	.program_mode_o	(program_mode_o),
	.wdt_suppress_o	(wdt_suppress_o),
	.cpu_reset_o	(cpu_reset_o),
	.busy_o		(busy_o),
	.sda_oe_o	(sda_oe_o),
	.flash_cmd_o	(flash_cmd_o)
);

`default_nettype wire

// ===== sim/isp_host_model.sv
// two-wire bus host that drives the flash programming slave
`timescale 1ns/100ps
`default_nettype none

module isp_host_model (
	// bus pins, data is open drain: sda_low_o pulls the line low
	output logic		scl_o,
	output logic		sda_low_o,
	input wire logic	sda_i
);
	// quarter of the 80 ns bus clock; the clock stands high between frames
	localparam int Q = 20;

	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task automatic start();
		sda_low_o = 1'b0;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b1;
		#Q scl_o = 1'b0;
		#Q;
	endtask

	task automatic stop();
		sda_low_o = 1'b1;
		#Q scl_o = 1'b1;
		#Q sda_low_o = 1'b0;
		#Q;
	endtask

	// one byte msb first, then the ack bit; hk is the host's own ack on a read
	task automatic xfer(input logic [7:0] b, input logic rd, input logic hk,
			output logic [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low_o = !rd && !b[i];
			#Q scl_o = 1'b1;
			#Q q[i] = sda_i;
			#Q scl_o = 1'b0;
			#Q;
		end
		sda_low_o = rd && hk;
		#Q scl_o = 1'b1;
		#Q ack = !sda_i;
		#Q scl_o = 1'b0;
		#Q;
	endtask
endmodule

`default_nettype wire

// ===== sim/i2c_flash_program_slave_tb.sv
// self-checking bench for the flash programming slave
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; $display("[ERR] %0t got %h want %h", $time, a, e); end end

module i2c_flash_program_slave_tb;
	import isp_pkg::*;
	localparam int unsigned	PROG	= 300;
	localparam int unsigned	ERASE	= 600;
	logic		core_clk_i = 1'b0, rst_n_i = 1'b0, key_wr_i = 1'b0, cpu_idle_i = 1'b0;
	logic [7:0]	key = 8'h00, peer_reg = 8'h00, q, d;
	logic [15:0]	rdata = 16'h0000;
	logic		program_mode_o, wdt_suppress_o, cpu_reset_o, busy_o, scl, host_low, sda_line;
	logic		sda_o, sda_oe_o, a;
	flash_cmd_t	flash_cmd_o;
	flash_cmd_t	sq[$];
	int		fails = 0, check_count = 0, crc = 32'hFFFF, resets = 0, n;
	logic [31:0]	rs = 32'hE;
	logic [5:0]	peer;

	always #2 core_clk_i = !core_clk_i;
	assign sda_line = !(host_low || (sda_oe_o && !sda_o));
	always @(negedge core_clk_i) rdata <= flash_cmd_o.addr ^ 16'h5A3C;
	always @(negedge core_clk_i) begin
		if (flash_cmd_o.strobe === 1'b1) sq.push_back(flash_cmd_o);
		if (cpu_reset_o === 1'b1) resets++;
	end

	i2c_flash_program_slave #(.ERASE_CYCLES(ERASE), .PROGRAM_CYCLES(PROG)) i2c_flash_program_slave_inst (
		.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .key_wr_i(key_wr_i),
		.program_mode_key_reg_i(key), .program_peer_address_reg_i(peer_reg),
		.cpu_idle_i(cpu_idle_i), .program_mode_o(program_mode_o), .wdt_suppress_o(wdt_suppress_o),
		.cpu_reset_o(cpu_reset_o), .busy_o(busy_o), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .flash_cmd_o(flash_cmd_o), .flash_rdata_i(rdata));
	isp_host_model isp_host_model_inst (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_line));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic int crc8(input int c, input logic [7:0] b);
		int f;
		for (int i = 7; i >= 0; i--) begin
			f = c[15] ^ b[i];
			c = ((c << 1) & 32'hFFFF) ^ (f ? 32'h8005 : 32'h0);
		end
		return c;
	endfunction

	task automatic close_out();
		if (fails == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wb(input logic [7:0] b, input logic ea);
		isp_host_model_inst.xfer(b, 1'b0, 1'b0, q, a);
		`CHK(a, ea)
	endtask
	task automatic rb(input logic [7:0] e, input logic hk);
		isp_host_model_inst.xfer(8'hFF, 1'b1, hk, q, a);
		`CHK(q, e)
	endtask
	task automatic go(input logic [1:0] t, input logic ea);
		@(negedge core_clk_i);
		isp_host_model_inst.start();
		wb({peer, t}, ea);
	endtask
	task automatic cw(input logic [7:0] c, input logic [7:0] pg);
		go(2'h2, 1'b1);
		wb(c, 1'b1);
		wb(pg, 1'b1);
		isp_host_model_inst.stop();
	endtask
	task automatic ck(input flash_op_t op, input logic f, input logic [15:0] ad, input logic [15:0] wd);
		flash_cmd_t e;
		`CHK(sq.size(), 1)
		if (sq.size() > 0) begin
			e = sq.pop_front();
			`CHK({e.op, e.font, e.addr, (op == FL_PROGRAM) ? e.wdata : wd}, {op, f, ad, wd})
		end
	endtask
	task automatic cr(input logic [7:0] c, input logic [7:0] hi, input logic [7:0] lo);
		go(2'h3, 1'b1);
		rb(c, 1'b1);
		rb(hi, 1'b1);
		rb(lo, 1'b1);
		rb(crc[15:8], 1'b1);
		rb(crc[7:0], 1'b0);
		isp_host_model_inst.stop();
	endtask

	initial begin
		#300000;
		fails++;
		close_out();
	end

	initial begin
		rs = xs(rs);
		peer = rs[7:2];
		peer_reg = {peer, rs[1:0]};
		repeat (6) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		key_wr_i = 1'b1;
		key = 8'h92;
		cpu_idle_i = 1'b1;
		@(negedge core_clk_i) key_wr_i = 1'b0;
		go(2'h2, 1'b0);
		isp_host_model_inst.stop();
		repeat (4000) @(negedge core_clk_i);
		`CHK(program_mode_o, 1'b0)
		key_wr_i = 1'b1;
		key = 8'h93;
		@(negedge core_clk_i) key_wr_i = 1'b0;
		n = 1;
		while (program_mode_o !== 1'b1 && n < 6000) begin
			@(negedge core_clk_i);
			n++;
		end
		`CHK(n >= 3750 && n <= 5625, 1'b1)
		// code program: a byte sent inside the program cycle (PROG, 300 clocks here) must be refused
		cw(8'hA0, 8'h12);
		go(2'h0, 1'b1);
		wb(8'h34, 1'b1);
		for (int i = 0; i < 3; i++) begin
			if (i > 0) repeat (PROG) @(negedge core_clk_i);
			rs = xs(rs);
			d = rs[7:0];
			wb(d, 1'b1);
			ck(FL_PROGRAM, 1'b0, {8'h12, 8'h34 + 8'(i)}, {8'h00, d});
			crc = crc8(crc, d);
		end
		wb(8'hAA, 1'b0);
		`CHK(sq.size(), 0)
		`CHK(busy_o, 1'b1)
		isp_host_model_inst.stop();
		cr(8'hA0, 8'h12, 8'h37);
		// font word, upper byte first, bits 2:1 of the command set
		cw(8'hA7, 8'h05);
		go(2'h0, 1'b1);
		wb(8'h03, 1'b1);
		wb(8'h01, 1'b1);
		`CHK(sq.size(), 0)
		wb(8'h23, 1'b1);
		ck(FL_PROGRAM, 1'b1, {2'h0, 7'h05, 7'h03}, 16'h0123);
		isp_host_model_inst.stop();
		crc = crc8(crc8(crc, 8'h01), 8'h23);
		repeat (PROG) @(negedge core_clk_i);
		cw(8'hA0, 8'h40);
		go(2'h0, 1'b1);
		wb(8'hF0, 1'b1);
		isp_host_model_inst.stop();
		go(2'h1, 1'b1);
		for (int i = 0; i < 2; i++) rb(8'((16'h40F0 + 16'(i)) ^ 16'h5A3C), i == 0);
		isp_host_model_inst.stop();
		// page erase and blank, then crc clear and cpu reset, with bus traffic checked as refused while the page erase runs and after the cpu reset
		cw(8'h30, 8'h40);
		go(2'h0, 1'b1);
		wb(8'h00, 1'b1);
		wb(8'hEE, 1'b1);
		ck(FL_PAGE_ERASE, 1'b0, 16'h4000, 16'h0000);
		isp_host_model_inst.stop();
		go(2'h3, 1'b0);
		isp_host_model_inst.stop();
		repeat (ERASE) @(negedge core_clk_i);
		`CHK(busy_o, 1'b0)
		cw(8'h68, 8'h40);
		go(2'h0, 1'b1);
		wb(8'h00, 1'b1);
		wb(8'h11, 1'b1);
		ck(FL_BLANK, 1'b0, 16'h4000, 16'h0000);
		isp_host_model_inst.stop();
		repeat (ERASE) @(negedge core_clk_i);
		cw(8'hD0, 8'h40);
		go(2'h0, 1'b1);
		wb(8'h10, 1'b1);
		isp_host_model_inst.stop();
		crc = 32'hFFFF;
		cr(8'hD0, 8'h40, 8'h10);
		go(2'h2, 1'b1);
		wb(8'h48, 1'b1);
		isp_host_model_inst.stop();
		repeat (4) @(negedge core_clk_i);
		`CHK({resets, program_mode_o}, {32'h1, 1'b0})
		go(2'h3, 1'b0);
		isp_host_model_inst.stop();
		close_out();
	end
endmodule

`default_nettype wire
